/* File: include/mpe_pkg.sv */
// ----------------------------------------
// Magnetic post-processing constants
// ----------------------------------------
package mpe_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CTRL3 = 8'h5D;
  localparam logic [7:0] ADDR_SRC = 8'h5E;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;
  // Control field positions
  localparam int CTRL3_RAW = 7;
  localparam int CTRL3_SOS_LO = 4;
  localparam int CTRL3_THS_UPD = 3;
  localparam int CTRL3_ST_Z = 2;
  localparam int CTRL3_ST_XY_LO = 0;
  // Source flag positions
  localparam int SRC_THS = 2;
  localparam int SRC_VECM = 1;
  localparam int SRC_DRDY = 0;
  // Decimation table
  localparam logic [10:0] DECIM_BASE = 11'h010;
  localparam logic [10:0] DECIM_MIN = 11'h002;
  localparam logic [2:0] ODR_800 = 3'h0;
  // Right shift of the 1.56 Hz column for each rate code
  localparam logic [3:0] DECIM_SHIFT [8] = '{4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h3, 4'h2, 4'h0};
endpackage

/* File: design/mpe_postprocess.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Raw bit clear: subtract stored offsets
// - Raw bit set: pass samples unchanged
// - Auto-sleep uses separate oversample code
// - Update select 0: refresh all axes
// - Update select 1: refresh triggering axis
// - Z self-test follows its enable bit
// - XY self-test on when field nonzero
// - Decimation from rate and oversample table
// - Threshold flag in source bit 2
// - Vector flag in source bit 1
// - Data-ready flag in source bit 0
// - Distance above threshold past debounce: event
// - Zero reference gives absolute magnitude check
// - Vector references kept internal, unreadable
// - Latched vector flag cleared on source read
// - Active state uses active oversample code
module mpe_postprocess #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Register access from serial interface
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Sensor operating state
  input wire logic auto_sleep_i,
  input wire logic [2:0] odr_code_i,
  input wire logic [2:0] active_oversample_code_i,
  // Raw samples and stored offsets
  input wire logic sample_valid_i,
  input wire logic [DATA_W-1:0] mag_x_i,
  input wire logic [DATA_W-1:0] mag_y_i,
  input wire logic [DATA_W-1:0] mag_z_i,
  input wire logic [DATA_W-1:0] off_x_i,
  input wire logic [DATA_W-1:0] off_y_i,
  input wire logic [DATA_W-1:0] off_z_i,
  // Threshold detector events
  input wire logic ths_event_i,
  input wire logic [2:0] ths_axis_i,
  // Vector-magnitude configuration
  input wire logic vecm_en_i,
  input wire logic vecm_latch_en_i,
  input wire logic vecm_init_mode_i,
  input wire logic vecm_upd_dis_i,
  input wire logic [14:0] vecm_ths_i,
  input wire logic [7:0] vecm_dbcnt_i,
  input wire logic [DATA_W-1:0] vecm_init_x_i,
  input wire logic [DATA_W-1:0] vecm_init_y_i,
  input wire logic [DATA_W-1:0] vecm_init_z_i,
  // Processed outputs
  output logic out_valid_o,
  output logic [DATA_W-1:0] out_x_o,
  output logic [DATA_W-1:0] out_y_o,
  output logic [DATA_W-1:0] out_z_o,
  output logic [2:0] os_code_o,
  output logic [10:0] decim_count_o,
  output logic z_selftest_o,
  output logic xy_selftest_o,
  output logic [2:0] ths_ref_update_o
);

  localparam int SQ_W = 2 * DATA_W + 2;
  localparam int SUM_W = SQ_W + 2;

  if (DATA_W < 16 || DATA_W > 24)
  begin : g_chk
    $error("DATA_W must be 16 to 24");
  end

  // Square of a signed difference
  function automatic logic [SQ_W-1:0] sq(input logic signed [DATA_W:0] d);
    logic signed [SQ_W-1:0] p;
    p = SQ_W'(d) * SQ_W'(d);
    return SQ_W'(p);
  endfunction

  // Signed difference of two samples
  function automatic logic signed [DATA_W:0] dif(input logic [DATA_W-1:0] a,
                                                 input logic [DATA_W-1:0] b);
    return $signed({a[DATA_W-1], a}) - $signed({b[DATA_W-1], b});
  endfunction

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [7:0] ctrl3_reg;
  logic [2:0] src_reg;
  logic src_read;
  assign src_read = reg_rd_i && (reg_addr_i == mpe_pkg::ADDR_SRC);

  // Write of the third magnetic control register
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      ctrl3_reg <= mpe_pkg::CTRL3_RESET;
    else if (reg_wr_i && reg_addr_i == mpe_pkg::ADDR_CTRL3)
      ctrl3_reg <= reg_wdata_i;
  end

  // Read data, unmapped addresses read zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= mpe_pkg::SRC_RESET;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == mpe_pkg::ADDR_CTRL3)
        reg_rdata_o <= ctrl3_reg;
      else if (reg_addr_i == mpe_pkg::ADDR_SRC)
        reg_rdata_o <= {5'h00, src_reg};
      else
        reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Sample path and settings
  // ----------------------------------------
  // Offset application or bypass
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      out_valid_o <= 1'b0;
      out_x_o <= '0;
      out_y_o <= '0;
      out_z_o <= '0;
    end
    else
    begin
      out_valid_o <= sample_valid_i;
      if (sample_valid_i)
      begin
        if (ctrl3_reg[mpe_pkg::CTRL3_RAW])
        begin
          out_x_o <= mag_x_i;
          out_y_o <= mag_y_i;
          out_z_o <= mag_z_i;
        end
        else
        begin
          out_x_o <= mag_x_i - off_x_i;
          out_y_o <= mag_y_i - off_y_i;
          out_z_o <= mag_z_i - off_z_i;
        end
      end
    end
  end

  // Oversample selection and decimation lookup
  logic [2:0] os_sel;
  logic [10:0] dec_raw;
  always_comb
  begin
    os_sel = auto_sleep_i ? ctrl3_reg[mpe_pkg::CTRL3_SOS_LO +: 3] : active_oversample_code_i;
    // table as shifted 1.56 Hz column
    dec_raw = (mpe_pkg::DECIM_BASE << ((os_sel == 3'h0) ? 3'h0 : os_sel - 3'h1))
              >> mpe_pkg::DECIM_SHIFT[odr_code_i];
  end

  // Registered settings and self-test enables
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      os_code_o <= 3'h0;
      decim_count_o <= mpe_pkg::DECIM_MIN;
      z_selftest_o <= 1'b0;
      xy_selftest_o <= 1'b0;
    end
    else
    begin
      os_code_o <= os_sel;
      decim_count_o <= (dec_raw < mpe_pkg::DECIM_MIN) ? mpe_pkg::DECIM_MIN : dec_raw;
      z_selftest_o <= ctrl3_reg[mpe_pkg::CTRL3_ST_Z];
      xy_selftest_o <= (ctrl3_reg[mpe_pkg::CTRL3_ST_XY_LO +: 2] != 2'b00);
    end
  end

  // Threshold reference update strobes, one cycle after each event cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      ths_ref_update_o <= 3'h0;
    else if (!ths_event_i)
      ths_ref_update_o <= 3'h0;
    else if (ctrl3_reg[mpe_pkg::CTRL3_THS_UPD])
      ths_ref_update_o <= ths_axis_i;
    else
      ths_ref_update_o <= 3'h7;
  end

  // ----------------------------------------
  // Vector-magnitude detector
  // ----------------------------------------
  // references have no read path
  logic [DATA_W-1:0] ref_x_reg, ref_y_reg, ref_z_reg;
  logic en_d_reg;
  logic [7:0] cnt_reg;
  logic vecm_evt_reg;
  logic [SUM_W-1:0] dist_sq;
  logic above;
  assign dist_sq = SUM_W'(sq(dif(out_x_o, ref_x_reg))) + SUM_W'(sq(dif(out_y_o, ref_y_reg)))
                   + SUM_W'(sq(dif(out_z_o, ref_z_reg)));
  assign above = dist_sq > SUM_W'({15'h0000, vecm_ths_i} * {15'h0000, vecm_ths_i});

  // Debounce counting and event
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !vecm_en_i)
    begin
      cnt_reg <= 8'h00;
      vecm_evt_reg <= 1'b0;
    end
    else if (out_valid_o)
    begin
      // reset debounce at or below threshold
      if (!above)
      begin
        cnt_reg <= 8'h00;
        vecm_evt_reg <= 1'b0;
      end
      else
      begin
        if (cnt_reg != 8'hFF)
          cnt_reg <= cnt_reg + 8'h01;
        vecm_evt_reg <= (cnt_reg >= vecm_dbcnt_i);
      end
    end
  end

  // Reference load on enable and update on event
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      en_d_reg <= 1'b0;
      ref_x_reg <= '0;
      ref_y_reg <= '0;
      ref_z_reg <= '0;
    end
    else
    begin
      en_d_reg <= vecm_en_i;
      if (vecm_en_i && (!en_d_reg || (vecm_init_mode_i && vecm_upd_dis_i)) && vecm_init_mode_i)
      begin
        ref_x_reg <= vecm_init_x_i;
        ref_y_reg <= vecm_init_y_i;
        ref_z_reg <= vecm_init_z_i;
      end
      else if (vecm_en_i && (!en_d_reg || (vecm_evt_reg && !vecm_upd_dis_i)))
      begin
        ref_x_reg <= out_x_o;
        ref_y_reg <= out_y_o;
        ref_z_reg <= out_z_o;
      end
    end
  end

  // ----------------------------------------
  // Event source flags
  // ----------------------------------------
  // Sticky flags (vector flag only when latched), set wins over read clear
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      src_reg <= 3'h0;
    else
    begin
      src_reg[mpe_pkg::SRC_THS] <= ths_event_i || (src_reg[mpe_pkg::SRC_THS] && !src_read);
      src_reg[mpe_pkg::SRC_DRDY] <= sample_valid_i || (src_reg[mpe_pkg::SRC_DRDY] && !src_read);
      // latched until read, else real time
      if (vecm_latch_en_i)
        src_reg[mpe_pkg::SRC_VECM] <= vecm_evt_reg || (src_reg[mpe_pkg::SRC_VECM] && !src_read);
      else
        src_reg[mpe_pkg::SRC_VECM] <= vecm_evt_reg;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_offset_apply: assert property (sample_valid_i && !ctrl3_reg[7] |=>
    out_x_o == $past(mag_x_i) - $past(off_x_i)) else $error("offset not applied");
  chk_raw_bypass: assert property (sample_valid_i && ctrl3_reg[7] |=>
    out_z_o == $past(mag_z_i)) else $error("raw sample altered");
  chk_sleep_os: assert property (auto_sleep_i |=>
    os_code_o == $past(ctrl3_reg[6:4])) else $error("sleep oversample wrong");
  chk_active_os: assert property (!auto_sleep_i |=>
    os_code_o == $past(active_oversample_code_i)) else $error("active oversample wrong");
  chk_ref_all: assert property (ths_event_i && !ctrl3_reg[3] |=>
    ths_ref_update_o == 3'h7) else $error("not all axes updated");
  chk_ref_axis: assert property (ths_event_i && ctrl3_reg[3] |=>
    ths_ref_update_o == $past(ths_axis_i)) else $error("wrong axis updated");
  chk_selftest_z: assert property ($rose(ctrl3_reg[2]) |=> z_selftest_o)
    else $error("z self-test not on");
  chk_selftest_xy: assert property (ctrl3_reg[1:0] == 2'b00 |=> !xy_selftest_o)
    else $error("xy self-test not off");
  chk_decim_800: assert property (odr_code_i == 3'h0 |=> decim_count_o == 11'h002)
    else $error("800 Hz decimation not 2");
  chk_ths_flag: assert property (ths_event_i |=> src_reg[2])
    else $error("threshold flag lost");
  chk_drdy_flag: assert property (sample_valid_i |=> src_reg[0] && out_valid_o)
    else $error("data-ready flag lost");
  chk_vecm_latch: assert property (vecm_latch_en_i && src_reg[1] && !src_read |=>
    src_reg[1]) else $error("latched vector flag dropped");
  chk_vecm_flag: assert property (vecm_evt_reg |=> src_reg[1])
    else $error("vector flag not set");
  chk_vecm_below: assert property (out_valid_o && !above |=> !vecm_evt_reg)
    else $error("event while below threshold");
  chk_vecm_event: assert property ($rose(vecm_evt_reg) |-> cnt_reg > vecm_dbcnt_i)
    else $error("event before debounce");

  cov_vecm_event: cover property ($rose(vecm_evt_reg));
  cov_src_clear: cover property (src_reg[0] && src_read ##1 !src_reg[0]);
  cov_sleep_os: cover property (auto_sleep_i && sample_valid_i);
  cov_axis_update: cover property (ths_event_i && ctrl3_reg[3]);

endmodule
`default_nettype wire

/* File: tb/mpe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host processor side of the register port
module mpe_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Register strobes and data
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  // Idle bus at time zero
  initial
  begin
    {addr_o, wr_o, wdata_o, rd_o} = 18'h0;
  end
  // One access of one cycle, then the bus shows changed values
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(posedge ref_clk_i);
    #1 {wr_o, rd_o} = 2'h0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_magnetometer_postprocess_events.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_magnetometer_postprocess_events;
  logic clk, rst_n, sv, te, ven, vlat, vinit, vupd, asl, rd_q, ov, zst, xyst, hw, hr;
  logic [2:0] odr, aos, tax, os, tru;
  logic [15:0] mx, my, mz, ox, oy, oz, vix, qx, qy, qz;
  logic [14:0] vths;
  logic [7:0] vdb, ctrl, ha, hd, rdata, er;
  logic [10:0] dec;
  logic [47:0] es;
  logic [7:0] rq[$];
  logic [47:0] sq[$];
  int seed, checks, err_count;
  // Clock of 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  mpe_host_model host (.ref_clk_i(clk), .addr_o(ha), .wr_o(hw), .wdata_o(hd), .rd_o(hr));
  mpe_postprocess #(.DATA_W(16)) DUT (.ref_clk_i(clk), .reset_n_i(rst_n),
    .reg_addr_i(ha), .reg_wr_i(hw), .reg_wdata_i(hd), .reg_rd_i(hr), .reg_rdata_o(rdata),
    .auto_sleep_i(asl), .odr_code_i(odr), .active_oversample_code_i(aos),
    .sample_valid_i(sv), .mag_x_i(mx), .mag_y_i(my), .mag_z_i(mz),
    .off_x_i(ox), .off_y_i(oy), .off_z_i(oz), .ths_event_i(te), .ths_axis_i(tax),
    .vecm_en_i(ven), .vecm_latch_en_i(vlat), .vecm_init_mode_i(vinit),
    .vecm_upd_dis_i(vupd), .vecm_ths_i(vths), .vecm_dbcnt_i(vdb), .vecm_init_x_i(vix),
    .vecm_init_y_i(16'h0000), .vecm_init_z_i(16'h0000), .out_valid_o(ov),
    .out_x_o(qx), .out_y_o(qy), .out_z_o(qz), .os_code_o(os), .decim_count_o(dec),
    .z_selftest_o(zst), .xy_selftest_o(xyst), .ths_ref_update_o(tru));
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Expected decimation from rate and oversample code
  function automatic logic [10:0] dexp(input int r, input int o);
    int sh [8] = '{9, 8, 7, 6, 5, 3, 2, 0};
    int v;
    v = ((o == 0) ? 16 : (16 << (o - 1))) >> sh[r];
    return 11'((v < 2) ? 2 : v);
  endfunction
  // Register read with its expected byte queued
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  // Control write, kept for expectations
  task automatic wr(input logic [7:0] d);
    ctrl = d;
    host.acc(1'b1, mpe_pkg::ADDR_CTRL3, d);
  endtask
  // Back-to-back samples, random or X only
  task automatic samp(input int n, input logic r, input logic [15:0] x);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1 sv = 1'b1;
      mx = r ? 16'($random(seed)) : x;
      my = r ? 16'($random(seed)) : 16'h0000;
      mz = r ? 16'($random(seed)) : 16'h0000;
      sq.push_back(ctrl[7] ? {mx, my, mz} : {mx - ox, my - oy, mz - oz});
    end
    @(posedge clk);
    #1 sv = 1'b0;
  endtask
  // Watcher: read data and samples against the oldest note
  always @(negedge clk) rd_q <= hr;
  always @(posedge clk)
  begin
    #2;
    if (rd_q === 1'b1)
    begin
      er = rq.pop_front();
      `CHK(rdata, er)
    end
    if (ov === 1'b1)
    begin
      es = sq.pop_front();
      `CHK({qx, qy, qz}, es)
    end
  end
  // Watchdog
  initial
  begin
    repeat (50000) @(posedge clk);
    err_count++;
    final_report();
  end
  // Main sequence
  initial
  begin
    seed = 32'h1471;
    {asl, odr, aos, sv, mx, my, mz, te, tax, ven, vlat, vinit, vupd, vths, vdb, vix} = '0;
    {rst_n, checks, err_count, ctrl} = '0;
    ox = 16'($random(seed));
    oy = 16'($random(seed));
    oz = 16'($random(seed));
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK(dec, 11'h002)
    rd(mpe_pkg::ADDR_SRC, 8'h00);
    host.acc(1'b1, 8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    rd(mpe_pkg::ADDR_CTRL3, 8'h00);
    samp(4, 1'b1, 16'h0000);
    rd(mpe_pkg::ADDR_SRC, 8'h01);
    rd(mpe_pkg::ADDR_SRC, 8'h00);
    wr(8'h80);
    samp(4, 1'b1, 16'h0000);
    rd(mpe_pkg::ADDR_SRC, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h80 | 8'(i));
      @(posedge clk);
      #2 `CHK({zst, xyst}, {i[2], i[1:0] != 2'h0})
    end
    for (int i = 0; i < 8; i++)
    begin
      aos = 3'(7 - i);
      wr(8'h80 | 8'(i << 4));
      asl = i[0];
      repeat (2) @(posedge clk);
      #1 `CHK(os, i[0] ? 3'(i) : 3'(7 - i))
    end
    asl = 1'b0;
    for (int r = 0; r < 64; r++)
    begin
      odr = 3'(r >> 3);
      aos = 3'(r);
      repeat (2) @(posedge clk);
      #1 `CHK(dec, dexp(r >> 3, r % 8))
    end
    for (int u = 0; u < 2; u++)
    begin
      wr(8'h80 | 8'(u << 3));
      @(posedge clk);
      #1 te = 1'b1;
      tax = 3'h2;
      @(posedge clk);
      #1 te = 1'b0;
      #1 `CHK(tru, u ? 3'h2 : 3'h7)
      rd(mpe_pkg::ADDR_SRC, 8'h04);
      rd(mpe_pkg::ADDR_SRC, 8'h00);
    end
    vths = 15'h0064;
    vdb = 8'h02;
    {vinit, vupd, vlat} = 3'h7;
    @(posedge clk);
    #1 ven = 1'b1;
    samp(2, 1'b0, 16'h00C8);
    rd(mpe_pkg::ADDR_SRC, 8'h01);
    samp(1, 1'b0, 16'h00C8);
    @(posedge clk);
    rd(mpe_pkg::ADDR_SRC, 8'h03);
    samp(1, 1'b0, 16'h0064);
    rd(mpe_pkg::ADDR_SRC, 8'h03);
    rd(mpe_pkg::ADDR_SRC, 8'h00);
    samp(2, 1'b0, 16'h00C8);
    rd(mpe_pkg::ADDR_SRC, 8'h01);
    vlat = 1'b0;
    samp(1, 1'b0, 16'h00C8);
    samp(1, 1'b0, 16'h0000);
    @(posedge clk);
    rd(mpe_pkg::ADDR_SRC, 8'h01);
    vix = 16'h00C8;
    samp(4, 1'b0, 16'h00C8);
    rd(mpe_pkg::ADDR_SRC, 8'h01);
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
